// File: nvm_prog_pkg.sv
// Constants shared by the serial nonvolatile programming sequencer.
package nvm_prog_pkg;

	// Command chain layout: seven-bit opcode above an eight-bit argument.
	localparam int unsigned CMD_W     = 15;
	localparam int unsigned OP_LSB    = 8;
	localparam int unsigned POLL_BIT  = 9;
	localparam int unsigned SYNC_W    = 7;

	// Bulk transfer geometry.
	localparam int unsigned PAGE_BYTES = 128;
	localparam int unsigned BUF_W      = 16;
	localparam int unsigned BUF_DEPTH  = 2;

	// Opcodes carried in the command chain.
	localparam logic [6:0] OP_NOP     = 7'h00;
	localparam logic [6:0] OP_MODE    = 7'h01;
	localparam logic [6:0] OP_ADDR_HI = 7'h02;
	localparam logic [6:0] OP_ADDR_LO = 7'h03;
	localparam logic [6:0] OP_DATA_LO = 7'h04;
	localparam logic [6:0] OP_DATA_HI = 7'h05;
	localparam logic [6:0] OP_WRITE   = 7'h06;
	localparam logic [6:0] OP_POLL    = 7'h07;
	localparam logic [6:0] OP_READ    = 7'h08;

	// Access modes selected by OP_MODE.
	localparam logic [3:0] MODE_NONE    = 4'h0;
	localparam logic [3:0] MODE_FLASH_W = 4'h1;
	localparam logic [3:0] MODE_FLASH_R = 4'h2;
	localparam logic [3:0] MODE_EE_W    = 4'h3;
	localparam logic [3:0] MODE_EE_R    = 4'h4;
	localparam logic [3:0] MODE_FUSE_W  = 4'h5;
	localparam logic [3:0] MODE_LOCK_W  = 4'h6;
	localparam logic [3:0] MODE_FL_R    = 4'h7;
	localparam logic [3:0] MODE_SIG_R   = 4'h8;
	localparam logic [3:0] MODE_CAL_R   = 4'h9;

	// Memory spaces presented on the array port.
	localparam logic [2:0] SP_FLASH    = 3'h0;
	localparam logic [2:0] SP_EEPROM   = 3'h1;
	localparam logic [2:0] SP_FUSE_EXT = 3'h2;
	localparam logic [2:0] SP_FUSE_HI  = 3'h3;
	localparam logic [2:0] SP_FUSE_LO  = 3'h4;
	localparam logic [2:0] SP_LOCK     = 3'h5;
	localparam logic [2:0] SP_SIG      = 3'h6;
	localparam logic [2:0] SP_CAL      = 3'h7;

	// Reset values.
	localparam logic [CMD_W-1:0] CMD_RST  = 15'h0000;
	localparam logic [15:0]      ADDR_RST = 16'h0000;
	localparam logic [7:0]       BYTE_RST = 8'h00;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_RD   = 3'b010,
		ST_WR   = 3'b100
	} seq_state_t;

endpackage : nvm_prog_pkg

// File: nvm_two_buf.sv
// Small first-in first-out buffer with valid and ready on both sides.
`timescale 1ns/1ps
`default_nettype none
module nvm_two_buf #(
	parameter int unsigned W     = 16,
	parameter int unsigned DEPTH = 2
) (
	// Clock and reset
	input  wire logic         mclk_i,
	input  wire logic         nrst_i,
	// Filling side
	input  wire logic         in_valid_i,
	output logic              in_ready_o,
	input  wire logic [W-1:0] in_data_i,
	// Draining side
	output logic              out_valid_o,
	input  wire logic         out_ready_i,
	output logic [W-1:0]      out_data_o
);
	localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [W-1:0] mem_r [DEPTH];
	logic [PW-1:0] wp_r;
	logic [PW-1:0] rp_r;
	logic [PW:0]   cnt_r;
	wire           push = in_valid_i & in_ready_o;
	wire           pop  = out_valid_o & out_ready_i;

	// The count is one bit wider than the pointers, so full is compared at
	// that width; a pointer-wide cast of the depth would wrap to zero.
	assign in_ready_o  = (cnt_r != (PW+1)'(DEPTH));
	assign out_valid_o = (cnt_r != '0);
	assign out_data_o  = mem_r[rp_r];

	function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
		bump = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
	endfunction : bump

	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			wp_r  <= '0;
			rp_r  <= '0;
			cnt_r <= '0;
		end else begin
			if (push) wp_r <= bump(wp_r);
			if (pop) rp_r <= bump(rp_r);
			cnt_r <= (PW+1)'(cnt_r + push - pop);
		end
	end

	// Storage carries no reset; it is only read while valid.
	always_ff @(posedge mclk_i) begin
		if (push) mem_r[wp_r] <= in_data_i;
	end

endmodule : nvm_two_buf
`default_nettype wire

// File: nvm_prog_seq.sv
// Serial-port programming sequencer for flash, EEPROM, fuses and lock bits.
`timescale 1ns/1ps
`default_nettype none
module nvm_prog_seq
	import nvm_prog_pkg::*;
(
	// Clock and reset
	input  wire logic        mclk_i,
	input  wire logic        nrst_i,
	// Test port pins and instruction selects
	input  wire logic        tck_i,
	input  wire logic        tdi_i,
	input  wire logic        shift_dr_i,
	input  wire logic        update_dr_i,
	input  wire logic        prog_command_instr_i,
	input  wire logic        bulk_page_load_instr_i,
	input  wire logic        bulk_page_read_instr_i,
	output logic             tdo_o,
	output logic             tdo_oe_o,
	// Array access port
	output logic             nvm_wr_o,
	output logic             nvm_rd_o,
	output logic [2:0]       nvm_space_o,
	output logic [15:0]      nvm_addr_o,
	output logic [7:0]       nvm_wdata_o,
	input  wire logic        nvm_busy_i,
	input  wire logic        nvm_rvalid_i,
	input  wire logic [7:0]  nvm_rdata_i,
	input  wire logic [7:0]  lock_bits_i,
	// Page buffer fill port
	output logic             pbuf_valid_o,
	input  wire logic        pbuf_ready_i,
	output logic [7:0]       pbuf_addr_o,
	output logic [7:0]       pbuf_data_o
);
	// Two-stage synchronisers; only the second stage is read.
	logic [SYNC_W-1:0] pin_s1_r;
	logic [SYNC_W-1:0] pin_s2_r;
	logic              tck_d_r;
	logic              upd_d_r;
	logic              rdi_d_r;

	wire tck_s   = pin_s2_r[6];
	wire tdi_s   = pin_s2_r[5];
	wire shift_s = pin_s2_r[4];
	wire upd_s   = pin_s2_r[3];
	wire cmdi_s  = pin_s2_r[2];
	wire ldi_s   = pin_s2_r[1];
	wire rdi_s   = pin_s2_r[0];

	wire tck_rise = tck_s & ~tck_d_r;
	wire tck_fall = ~tck_s & tck_d_r;
	wire upd_rise = upd_s & ~upd_d_r;

	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			pin_s1_r <= '0;
			pin_s2_r <= '0;
			tck_d_r  <= 1'b0;
			upd_d_r  <= 1'b0;
			rdi_d_r  <= 1'b0;
		end else begin
			pin_s1_r <= {tck_i, tdi_i, shift_dr_i, update_dr_i,
				prog_command_instr_i, bulk_page_load_instr_i,
				bulk_page_read_instr_i};
			pin_s2_r <= pin_s1_r;
			tck_d_r  <= tck_s;
			upd_d_r  <= upd_s;
			rdi_d_r  <= rdi_s;
		end
	end

	// Sequencer state.
	seq_state_t        st_r;
	logic [CMD_W-1:0]  cmd_sr_r;
	logic [3:0]        mode_r;
	logic [15:0]       addr_r;
	logic [7:0]        data_lo_r;
	logic [7:0]        byte_sr_r;
	logic [7:0]        next_r;
	logic [2:0]        bit_cnt_r;
	logic [7:0]        byte_cnt_r;
	logic [7:0]        rd_idx_r;
	logic              push_r;
	logic [BUF_W-1:0]  push_data_r;

	wire [6:0] op  = cmd_sr_r[CMD_W-1:OP_LSB];
	wire [7:0] arg = cmd_sr_r[7:0];

	function automatic logic [2:0] space_of(input logic [3:0] m,
		input logic [1:0] sel);
		logic [2:0] fsel;
		fsel = (sel == 2'h0) ? SP_FUSE_EXT :
			(sel == 2'h1) ? SP_FUSE_HI : SP_FUSE_LO;
		case (m)
			MODE_EE_W, MODE_EE_R: space_of = SP_EEPROM;
			MODE_FUSE_W:          space_of = fsel;
			MODE_LOCK_W:          space_of = SP_LOCK;
			MODE_FL_R:            space_of = (sel == 2'h3) ? SP_LOCK : fsel;
			MODE_SIG_R:           space_of = SP_SIG;
			MODE_CAL_R:           space_of = SP_CAL;
			default:              space_of = SP_FLASH;
		endcase
	endfunction : space_of

	// Command decode, all qualified by an update while the command chain is selected.
	wire exec      = upd_rise & cmdi_s & (st_r == ST_IDLE);
	wire is_ee     = (mode_r == MODE_EE_W) | (mode_r == MODE_EE_R);
	wire wr_mode   = (mode_r == MODE_FLASH_W) | (mode_r == MODE_EE_W) |
		(mode_r == MODE_FUSE_W) | (mode_r == MODE_LOCK_W);
	wire rd_mode   = (mode_r == MODE_FLASH_R) | (mode_r == MODE_EE_R) |
		(mode_r == MODE_FL_R) | (mode_r == MODE_SIG_R) |
		(mode_r == MODE_CAL_R);
	wire do_write  = exec & (op == OP_WRITE) & wr_mode;
	wire do_read   = exec & (op == OP_READ) & rd_mode;
	// Polls are answered even while a write is pending, or busy never shows.
	wire do_poll   = upd_rise & cmdi_s & (op == OP_POLL);
	wire do_lo     = exec & (op == OP_DATA_LO);
	wire do_hi     = exec & (op == OP_DATA_HI);

	// Bulk chains are gated off in EEPROM modes.
	wire ld_shift  = tck_rise & shift_s & ldi_s & ~is_ee
		& (mode_r == MODE_FLASH_W);
	wire rd_shift  = tck_rise & shift_s & rdi_s & ~is_ee
		& (mode_r == MODE_FLASH_R);
	wire cmd_shift = tck_rise & shift_s & cmdi_s;
	wire rd_start  = rdi_s & ~rdi_d_r & (mode_r == MODE_FLASH_R);
	wire byte_done = (bit_cnt_r == 3'h7);
	wire [7:0] ld_byte = {tdi_s, byte_sr_r[7:1]};

	// Page buffer pushes: word-wise halves, EEPROM bytes, or bulk bytes.
	wire push_lo   = do_lo & ((mode_r == MODE_FLASH_W) | (mode_r == MODE_EE_W));
	wire push_hi   = do_hi & (mode_r == MODE_FLASH_W);
	wire push_bulk = ld_shift & byte_done;
	wire [7:0] word_idx = {addr_r[6:0], 1'b0};
	wire [7:0] lo_idx   = (mode_r == MODE_EE_W) ? addr_r[7:0] : word_idx;
	wire [BUF_W-1:0] push_nxt = push_bulk ? {byte_cnt_r, ld_byte} :
		push_hi ? {word_idx | 8'h01, arg} : {lo_idx, arg};

	logic buf_in_ready;
	logic buf_out_valid;
	logic [BUF_W-1:0] buf_out_data;

	nvm_two_buf #(.W(BUF_W), .DEPTH(BUF_DEPTH)) u_buf (
		.mclk_i      (mclk_i),
		.nrst_i      (nrst_i),
		.in_valid_i  (push_r),
		.in_ready_o  (buf_in_ready),
		.in_data_i   (push_data_r),
		.out_valid_o (buf_out_valid),
		.out_ready_i (pbuf_ready_i),
		.out_data_o  (buf_out_data)
	);
	assign pbuf_valid_o = buf_out_valid;
	assign pbuf_addr_o  = buf_out_data[15:8];
	assign pbuf_data_o  = buf_out_data[7:0];

	// A write counts as finished only once queued page data has drained too.
	wire wr_done = (st_r != ST_WR) & ~push_r & ~buf_out_valid;

	// Bulk read address: page base plus running byte index.
	wire [15:0] page_base = {addr_r[14:0], 1'b0};
	wire [15:0] bulk_addr = 16'(page_base + {8'h00, rd_idx_r});
	wire        bulk_req  = rd_start | (rd_shift & byte_done);

	// Fuse data passes as given; lock data may only clear bits.
	wire [7:0] wr_byte = (mode_r == MODE_LOCK_W) ?
		(lock_bits_i & data_lo_r) : data_lo_r;

	wire [15:0] rd_addr = (mode_r == MODE_FLASH_R) ?
		{addr_r[14:0], arg[0]} : addr_r;

	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			st_r     <= ST_IDLE;
			nvm_wr_o <= 1'b0;
			nvm_rd_o <= 1'b0;
		end else begin
			nvm_wr_o <= do_write;
			nvm_rd_o <= do_read | bulk_req;
			case (st_r)
				ST_IDLE: begin
					if (do_write) st_r <= ST_WR;
					else if (do_read) st_r <= ST_RD;
				end
				ST_RD: begin
					if (nvm_rvalid_i) st_r <= ST_IDLE;
				end
				ST_WR: begin
					// The array raises busy the cycle after the strobe.
					if (!nvm_wr_o && !nvm_busy_i) st_r <= ST_IDLE;
				end
				default: st_r <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			nvm_space_o <= SP_FLASH;
			nvm_addr_o  <= ADDR_RST;
			nvm_wdata_o <= BYTE_RST;
		end else if (do_write) begin
			nvm_space_o <= space_of(mode_r, arg[1:0]);
			nvm_addr_o  <= addr_r;
			nvm_wdata_o <= wr_byte;
		end else if (do_read) begin
			nvm_space_o <= space_of(mode_r, arg[1:0]);
			nvm_addr_o  <= rd_addr;
		end else if (bulk_req) begin
			nvm_space_o <= SP_FLASH;
			nvm_addr_o  <= bulk_addr;
		end
	end

	// Command chain: shifts on the link, executes on update, captures answers.
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cmd_sr_r  <= CMD_RST;
			mode_r    <= MODE_NONE;
			addr_r    <= ADDR_RST;
			data_lo_r <= BYTE_RST;
		end else begin
			if (cmd_shift) cmd_sr_r <= {tdi_s, cmd_sr_r[CMD_W-1:1]};
			else if (do_poll) cmd_sr_r[POLL_BIT] <= wr_done;
			else if (st_r == ST_RD && nvm_rvalid_i) cmd_sr_r[7:0] <= nvm_rdata_i;
			if (exec && op == OP_MODE) mode_r <= arg[3:0];
			if (exec && op == OP_ADDR_HI) addr_r[15:8] <= arg;
			if (exec && op == OP_ADDR_LO) addr_r[7:0] <= arg;
			if (do_lo) data_lo_r <= arg;
		end
	end

	// Bulk chains share one eight-bit shift register.
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			byte_sr_r  <= BYTE_RST;
			next_r     <= BYTE_RST;
			bit_cnt_r  <= '0;
			byte_cnt_r <= '0;
			rd_idx_r   <= '0;
		end else begin
			if (!ldi_s && !rdi_s) begin
				bit_cnt_r  <= '0;
				byte_cnt_r <= '0;
				rd_idx_r   <= '0;
				byte_sr_r  <= BYTE_RST;
			end else if (ld_shift) begin
				byte_sr_r <= ld_byte;
				bit_cnt_r <= 3'(bit_cnt_r + 1'b1);
				if (byte_done) byte_cnt_r <= 8'(byte_cnt_r + 1'b1);
			end else if (rd_shift) begin
				bit_cnt_r <= 3'(bit_cnt_r + 1'b1);
				// The first eight shifts carry the empty register out.
				byte_sr_r <= byte_done ? next_r : {1'b0, byte_sr_r[7:1]};
			end
			if (bulk_req) rd_idx_r <= 8'(rd_idx_r + 1'b1);
			if (rdi_s && nvm_rvalid_i && st_r != ST_RD) next_r <= nvm_rdata_i;
		end
	end

	// One pending push; it waits for buffer space instead of dropping a byte.
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			push_r      <= 1'b0;
			push_data_r <= '0;
		end else if (push_lo || push_hi || push_bulk) begin
			push_r      <= 1'b1;
			push_data_r <= push_nxt;
		end else if (buf_in_ready) begin
			push_r <= 1'b0;
		end
	end

	// Output changes on the falling link edge so it is stable at the rise.
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			tdo_o    <= 1'b0;
			tdo_oe_o <= 1'b0;
		end else begin
			tdo_oe_o <= shift_s;
			if (tck_fall) tdo_o <= rdi_s ? byte_sr_r[0] : cmd_sr_r[0];
		end
	end

endmodule : nvm_prog_seq
`default_nettype wire

// File: nvm_prog_seq_monitor.sv
// Port-level assertions for the serial programming sequencer.
`timescale 1ns/1ps
`default_nettype none
module nvm_prog_seq_monitor
	import nvm_prog_pkg::*;
(
	// Clock, reset and link
	input wire logic       mclk_i,
	input wire logic       nrst_i,
	input wire logic       shift_dr_i,
	input wire logic       prog_command_instr_i,
	input wire logic       bulk_page_read_instr_i,
	input wire logic       tdo_oe_o,
	// Array and page buffer
	input wire logic       nvm_wr_o,
	input wire logic       nvm_busy_i,
	input wire logic       nvm_rd_o,
	input wire logic [2:0] nvm_space_o,
	input wire logic [7:0] nvm_wdata_o,
	input wire logic [7:0] lock_bits_i,
	input wire logic       pbuf_valid_o,
	input wire logic       pbuf_ready_i,
	input wire logic [7:0] pbuf_addr_o,
	input wire logic [7:0] pbuf_data_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!nrst_i);
	sequence s_stall;
		pbuf_valid_o && !pbuf_ready_i;
	endsequence
	sequence s_shift_on;
		shift_dr_i [*4];
	endsequence
	sequence s_shift_off;
		!shift_dr_i [*4];
	endsequence
	chk_wr_one_cycle: assert property (nvm_wr_o |=> !nvm_wr_o)
		else $error("write strobe longer than one cycle");
	chk_busy_no_wr: assert property (nvm_busy_i |-> !nvm_wr_o)
		else $error("write strobe while array busy");
	chk_lock_masked: assert property (nvm_wr_o && nvm_space_o == SP_LOCK
		|-> (nvm_wdata_o & ~lock_bits_i) == 8'h00)
		else $error("lock write releases a programmed bit");
	chk_bulk_flash: assert property (nvm_rd_o && bulk_page_read_instr_i
		|-> nvm_space_o == SP_FLASH)
		else $error("bulk read outside flash");
	chk_wr_cmd_only: assert property (nvm_wr_o |-> prog_command_instr_i)
		else $error("write without command chain");
	chk_stall_hold: assert property (s_stall |=> pbuf_valid_o
		&& $stable(pbuf_addr_o) && $stable(pbuf_data_o))
		else $error("page buffer entry changed under stall");
	chk_oe_drive: assert property (s_shift_on |-> tdo_oe_o)
		else $error("serial output not driven while shifting");
	chk_oe_release: assert property (s_shift_off |-> !tdo_oe_o)
		else $error("serial output driven outside shifting");
endmodule : nvm_prog_seq_monitor
bind nvm_prog_seq nvm_prog_seq_monitor mon (.mclk_i(mclk_i), .nrst_i(nrst_i),
	.shift_dr_i(shift_dr_i), .prog_command_instr_i(prog_command_instr_i),
	.bulk_page_read_instr_i(bulk_page_read_instr_i), .tdo_oe_o(tdo_oe_o),
	.nvm_wr_o(nvm_wr_o), .nvm_busy_i(nvm_busy_i), .nvm_rd_o(nvm_rd_o),
	.nvm_space_o(nvm_space_o), .nvm_wdata_o(nvm_wdata_o),
	.lock_bits_i(lock_bits_i), .pbuf_valid_o(pbuf_valid_o),
	.pbuf_ready_i(pbuf_ready_i), .pbuf_addr_o(pbuf_addr_o),
	.pbuf_data_o(pbuf_data_o));
`default_nettype wire

// File: nvm_link_driver.sv
// Test-port programmer model: chain shifts and command sequences.
`timescale 1ns/1ps
`default_nettype none
module nvm_link_driver (
	// System clock and serial return
	input  wire logic mclk_i,
	input  wire logic tdo_i,
	// Test port
	output logic      tck_o,
	output logic      tdi_o,
	output logic      shift_dr_o,
	output logic      update_dr_o,
	output logic      cmd_sel_o,
	output logic      load_sel_o,
	output logic      read_sel_o
);
	// The link clock rests high so no edge is seen between frames.
	initial begin
		{tck_o, tdi_o, shift_dr_o, update_dr_o} = 4'h8;
		{cmd_sel_o, load_sel_o, read_sel_o} = 3'h4;
	end
	task automatic sel(input logic [2:0] s);
		@(negedge mclk_i);
		{cmd_sel_o, load_sel_o, read_sel_o} = s;
		repeat (4) @(negedge mclk_i);
	endtask : sel
	// Bits go out LSB first; tdo is taken late in the low phase.
	task automatic shift(input int n, input logic [255:0] din,
			output logic [255:0] dout);
		dout = '0;
		@(negedge mclk_i);
		shift_dr_o = 1'b1;
		repeat (4) @(negedge mclk_i);
		for (int i = 0; i < n; i++) begin
			#1 tck_o = 1'b0;
			#31 dout[i] = tdo_i;
			tdi_o = din[i];
			#1 tck_o = 1'b1;
			#31;
		end
		tdi_o = ~tdi_o;
		repeat (4) @(negedge mclk_i);
		shift_dr_o = 1'b0;
	endtask : shift
	// Returns what the previous command left in the chain.
	task automatic cmd(input logic [6:0] op, input logic [7:0] arg,
			output logic [14:0] res);
		logic [255:0] d;
		shift(15, {241'h0, op, arg}, d);
		res = d[14:0];
		@(negedge mclk_i);
		update_dr_o = 1'b1;
		repeat (4) @(negedge mclk_i);
		update_dr_o = 1'b0;
		repeat (20) @(negedge mclk_i);
	endtask : cmd
endmodule : nvm_link_driver
`default_nettype wire

// File: nvm_prog_seq_test.sv
// Self-checking bench for the serial programming sequencer.
`timescale 1ns/1ps
`default_nettype none
module nvm_prog_seq_test;
	import nvm_prog_pkg::*;
	logic         mclk;
	logic         nrst;
	logic         tck, tdi, shift_dr, update_dr, s_cmd, s_load, s_read;
	logic         tdo, tdo_oe, wr, wr_d, rd, pv;
	logic         busy, rvalid, pr;
	logic [2:0]   space, rsp, wsp;
	logic [15:0]  addr, raddr, wa;
	logic [7:0]   wdata, wd, pa, pd, rdata, lock;
	logic [8:0]   bcnt;
	logic [2:0]   rwait;
	logic [15:0]  pq[$];
	logic [14:0]  res;
	logic [255:0] dq;
	int           rd_cnt = 0, miscompares = 0, comparisons = 0;
	// An unknown start counts as low, so the first half period ends rising.
	always #2.5 mclk = (mclk !== 1'b1);
	nvm_prog_seq dut (.mclk_i(mclk), .nrst_i(nrst), .tck_i(tck), .tdi_i(tdi),
		.shift_dr_i(shift_dr), .update_dr_i(update_dr),
		.prog_command_instr_i(s_cmd), .bulk_page_load_instr_i(s_load),
		.bulk_page_read_instr_i(s_read), .tdo_o(tdo), .tdo_oe_o(tdo_oe),
		.nvm_wr_o(wr), .nvm_rd_o(rd), .nvm_space_o(space), .nvm_addr_o(addr),
		.nvm_wdata_o(wdata), .nvm_busy_i(busy), .nvm_rvalid_i(rvalid),
		.nvm_rdata_i(rdata), .lock_bits_i(lock), .pbuf_valid_o(pv),
		.pbuf_ready_i(pr), .pbuf_addr_o(pa), .pbuf_data_o(pd));
	nvm_link_driver prg (.mclk_i(mclk), .tdo_i(tdo), .tck_o(tck), .tdi_o(tdi),
		.shift_dr_o(shift_dr), .update_dr_o(update_dr), .cmd_sel_o(s_cmd),
		.load_sel_o(s_load), .read_sel_o(s_read));
	// Fuse and lock reads ignore the address, so it is masked from the pattern.
	function automatic logic [7:0] rd_val(input logic [2:0] s, input logic [15:0] a);
		return {s, (s >= SP_FUSE_EXT && s <= SP_LOCK) ? 2'h0 : a[1:0], 3'h5};
	endfunction : rd_val
	// Array stand-in, driven on the falling edge: busy from the cycle after a
	// write strobe, data three cycles after a read strobe. It starts erased,
	// as if a chip erase had come before any programming.
	always @(negedge mclk) begin
		if (!nrst) begin
			busy   <= 1'b0;
			rvalid <= 1'b0;
			rdata  <= 8'h00;
			lock   <= 8'hFF;
			rwait  <= 3'h0;
			bcnt   <= 9'h000;
			wr_d   <= 1'b0;
			wa     <= 16'h0000;
		end else begin
			rvalid <= (rwait == 3'h1);
			rdata <= (rwait == 3'h1) ? rd_val(rsp, raddr) : ~rdata;
			if (rwait != 3'h0) rwait <= rwait - 3'h1;
			if (rd) begin
				rwait <= 3'h3;
				rsp <= space;
				raddr <= addr;
				rd_cnt <= rd_cnt + 1;
			end
			wr_d <= wr;
			busy <= wr_d || bcnt > 9'h1;
			bcnt <= wr_d ? 9'h12C : (bcnt != 9'h0 ? bcnt - 9'h1 : 9'h0);
			if (wr) begin
				wsp <= space;
				wd <= wdata;
				wa <= addr;
			end
			if (wr && space == SP_LOCK) lock <= wdata;
		end
	end
	// Page buffer transfers complete on the rising edge, so they are logged there.
	always @(posedge mclk) begin
		if (pv && pr) pq.push_back({pa, pd});
	end
	task automatic check(input string what, input logic [15:0] exp,
			input logic [15:0] got);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	task automatic op(input logic [6:0] o, input logic [7:0] a);
		prg.cmd(o, a, res);
	endtask : op
	task automatic poll_done();
		res = '0;
		for (int i = 0; i < 6 && res[POLL_BIT] !== 1'b1; i++) begin
			repeat (100) @(negedge mclk);
			op(OP_POLL, 8'h00);
			op(OP_NOP, 8'h00);
		end
		check("poll done", 16'h1, {15'h0, res[POLL_BIT]});
	endtask : poll_done
	task automatic t_write(input logic [3:0] m, input logic [7:0] d,
			input logic [1:0] s, input logic [2:0] sp, input logic [7:0] e);
		op(OP_MODE, {4'h0, m});
		op(OP_DATA_LO, d);
		wsp = 'x;
		wd = 'x;
		op(OP_WRITE, {6'h00, s});
		check("write space", {13'h0, sp}, {13'h0, wsp});
		check("write data", {8'h0, e}, {8'h0, wd});
		op(OP_POLL, 8'h00);
		op(OP_NOP, 8'h00);
		check("poll busy", 16'h0, {15'h0, res[POLL_BIT]});
		poll_done();
	endtask : t_write
	task automatic t_read(input logic [3:0] m, input logic [7:0] lo,
			input logic [7:0] a, input logic [2:0] sp, input logic [1:0] b);
		op(OP_MODE, {4'h0, m});
		op(OP_ADDR_HI, 8'h00);
		op(OP_ADDR_LO, lo);
		op(OP_READ, a);
		op(OP_NOP, 8'h00);
		check("read byte", {8'h0, rd_val(sp, {14'h0, b})},
			{8'h0, res[7:0]});
	endtask : t_read
	task automatic t_load();
		logic [23:0] ld = 24'hC35A96;
		op(OP_MODE, {4'h0, MODE_FLASH_W});
		op(OP_ADDR_HI, 8'h01);
		op(OP_ADDR_LO, 8'h05);
		pq.delete();
		op(OP_DATA_LO, 8'h11);
		op(OP_DATA_HI, 8'h22);
		check("word low", 16'h0A11, pq[0]);
		check("word high", 16'h0B22, pq[1]);
		op(OP_ADDR_LO, 8'h00);
		pq.delete();
		prg.sel(3'h2);
		pr = 1'b0;
		// The stall outlasts two bytes, so only the buffer keeps them.
		fork
			prg.shift(24, {232'h0, ld}, dq);
			begin
				repeat (300) @(negedge mclk);
				pr = 1'b1;
			end
		join
		prg.sel(3'h4);
		for (int i = 0; i < 3; i++)
			check("load byte", {i[7:0], ld[8*i +: 8]}, pq[i]);
		op(OP_WRITE, 8'h00);
		check("write addr", 16'h0100, wa);
		poll_done();
	endtask : t_load
	task automatic t_bulk_read();
		op(OP_MODE, {4'h0, MODE_FLASH_R});
		op(OP_ADDR_HI, 8'h00);
		op(OP_ADDR_LO, 8'h00);
		prg.sel(3'h1);
		prg.shift(32, '1, dq);
		prg.sel(3'h4);
		check("prefetch bits", 16'h0, {8'h0, dq[7:0]});
		for (int i = 0; i < 3; i++) check("page byte", {8'h0, rd_val(SP_FLASH, i[15:0])}, {8'h0, dq[8*i+8 +: 8]});
	endtask : t_bulk_read
	task automatic t_eeprom();
		int n;
		op(OP_MODE, {4'h0, MODE_EE_W});
		op(OP_ADDR_HI, 8'h00);
		op(OP_ADDR_LO, 8'h07);
		pq.delete();
		op(OP_DATA_LO, 8'h44);
		check("eeprom byte", 16'h0744, pq[0]);
		pq.delete();
		prg.sel(3'h2);
		prg.shift(16, '1, dq);
		prg.sel(3'h4);
		check("bulk loads", 16'h0, 16'(pq.size()));
		op(OP_MODE, {4'h0, MODE_EE_R});
		n = rd_cnt;
		prg.sel(3'h1);
		prg.shift(16, '0, dq);
		prg.sel(3'h4);
		check("bulk reads", n[15:0], rd_cnt[15:0]);
	endtask : t_eeprom
	task automatic complete_run();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : complete_run
	initial begin
		nrst = 1'b0;
		pr = 1'b1;
		repeat (2) @(negedge mclk);
		nrst = 1'b1;
		repeat (4) @(negedge mclk);
		for (int i = 0; i < 3; i++) t_write(MODE_FUSE_W, 8'h3C ^ i[7:0], i[1:0], SP_FUSE_EXT + i[2:0], 8'h3C ^ i[7:0]);
		t_write(MODE_LOCK_W, 8'hF0, 2'h0, SP_LOCK, 8'hF0);
		t_write(MODE_LOCK_W, 8'h0F, 2'h0, SP_LOCK, 8'h00);
		$display("done: fuse and lock writes");
		for (int i = 0; i < 3; i++) t_read(MODE_SIG_R, i[7:0], 8'h00, SP_SIG, i[1:0]);
		t_read(MODE_CAL_R, 8'h00, 8'h00, SP_CAL, 2'h0);
		for (int i = 0; i < 4; i++) t_read(MODE_FL_R, 8'h00, i[7:0], SP_FUSE_EXT + i[2:0], 2'h0);
		t_read(MODE_EE_R, 8'h06, 8'h00, SP_EEPROM, 2'h2);
		for (int i = 0; i < 2; i++) t_read(MODE_FLASH_R, 8'h01, i[7:0], SP_FLASH, {1'b1, i[0]});
		$display("done: word reads");
		t_load();
		$display("done: page load");
		t_bulk_read();
		$display("done: page read");
		t_eeprom();
		$display("done: eeprom");
		complete_run();
	end
	initial begin
		#400000;
		miscompares++;
		$display("ERROR watchdog expected finish seen timeout");
		complete_run();
	end
endmodule : nvm_prog_seq_test
`default_nettype wire
